// ==== core/dpi_init_ctrl.sv ====
// Functional notes
// - hold cke and odt low during power ramp
// - run memory clock before any command
// - wait 200 us, then nop and cke high
// - wait 400 ns before first precharge all
// - only nop during the 400 ns wait
// - program emr2, emr3, emr1 with dll on
// - mode set with dll reset, then precharge
// - at least two auto refreshes
// - mode set with a8 low
// - 200 cycles after dll reset before calibration
// - emr1 calibration default, then calibration exit
// - refresh every 7.8 us on average
// - mode set is all low, bank 0
// - emr1 write uses bank bit 0 high
// - emr2 write uses bank bit 1 high
//
// Local design decisions: the address map and the plain strobed port.
module dpi_init_ctrl
  import dpi_pkg::*;
#(
  parameter int STABLE_WAIT  = STABLE_CYCLES,
  parameter int REFRESH_WAIT = REFRESH_CYCLES
) (
  // clock and reset
  input  wire logic              clk_in,
  input  wire logic              reset_n_in,
  input  wire logic              clk_en_in,
  // register port
  input  wire logic [3:0]        reg_addr_in,
  input  wire logic [15:0]       reg_wdata_in,
  input  wire logic              reg_write_in,
  input  wire logic              reg_read_in,
  output logic      [15:0]       reg_rdata_out,
  // memory pins
  output logic                   mem_clk_en_out,
  output logic                   mem_cke_out,
  output logic                   mem_odt_out,
  output logic                   mem_cs_n_out,
  output logic                   mem_ras_n_out,
  output logic                   mem_cas_n_out,
  output logic                   mem_we_n_out,
  output logic      [2:0]        mem_ba_out,
  output logic      [ADDR_W-1:0] mem_addr_out,
  // status
  output logic                   ready_out
);

  // ************************************************************
  // sequence states
  // ************************************************************
  // the states run in the one fixed order that the memory needs at power-up;
  // a start pulse seen outside ST_OFF is ignored on purpose, because going
  // through the sequence again without lowering cke first would leave the
  // memory in an unknown state. ST_READY and ST_AUTO_REF together form the
  // normal-operation loop that only keeps the memory refreshed.
  typedef enum logic [4:0] {
    ST_OFF, ST_STABLE, ST_CKE_WAIT, ST_PRE1, ST_EMR2, ST_EMR3, ST_EMR1,
    ST_MR_RESET, ST_PRE2, ST_REF, ST_MR_RUN, ST_LOCK, ST_CAL_DEF, ST_CAL_EXIT,
    ST_READY, ST_AUTO_REF
  } dpi_state_t;

  dpi_state_t        state;
  logic              start;
  logic [31:0]       wait_cnt;
  logic [31:0]       lock_cnt;
  logic [31:0]       ref_timer;
  logic [3:0]        ref_done;
  logic [15:0]       ref_total;
  logic [ADDR_W-1:0] mr_val;
  logic [ADDR_W-1:0] emr1_val;
  logic [ADDR_W-1:0] emr2_val;
  logic [ADDR_W-1:0] emr3_val;
  logic [3:0]        min_refs;
  logic              waiting;

  assign waiting = (wait_cnt != 32'h_0000_0000);

  // ************************************************************
  // register port
  // ************************************************************
  // the mode values are kept as software wrote them. Operating options such
  // as latencies, burst length, strobe mode and mask mode live only in these
  // words, and the sequencer overrides just the dll and calibration bits.
  // A register that is written while the sequence runs takes effect at its
  // next use; earlier commands are not sent again.
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      start    <= 1'b0;
      min_refs <= 4'(MIN_REFRESHES);
      mr_val   <= '0;
      emr1_val <= '0;
      emr2_val <= '0;
      emr3_val <= '0;
    end else if (clk_en_in) begin
      start <= 1'b0;
      if (reg_write_in) begin
        case (reg_addr_in)
          REG_CONTROL: begin
            start <= reg_wdata_in[0];
            if (reg_wdata_in[7:4] >= 4'(MIN_REFRESHES))
              min_refs <= reg_wdata_in[7:4];
          end
          // latency and burst fields pass to the memory unchanged
          REG_MR:   mr_val   <= reg_wdata_in[ADDR_W-1:0];
          // strobe, mask and additive latency selections
          REG_EMR1: emr1_val <= reg_wdata_in[ADDR_W-1:0];
          REG_EMR2: emr2_val <= reg_wdata_in[ADDR_W-1:0];
          REG_EMR3: emr3_val <= reg_wdata_in[ADDR_W-1:0];
          default: ;
        endcase
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      reg_rdata_out <= 16'h_0000;
    end else if (clk_en_in) begin
      reg_rdata_out <= 16'h_0000;
      if (reg_read_in) begin
        case (reg_addr_in)
          REG_CONTROL: reg_rdata_out <= {12'h_000, min_refs};
          REG_STATUS:  reg_rdata_out <= {10'h_000, (state == ST_READY || state == ST_AUTO_REF), state};
          REG_MR:      reg_rdata_out <= {2'b00, mr_val};
          REG_EMR1:    reg_rdata_out <= {2'b00, emr1_val};
          REG_EMR2:    reg_rdata_out <= {2'b00, emr2_val};
          REG_EMR3:    reg_rdata_out <= {2'b00, emr3_val};
          REG_REFCNT:  reg_rdata_out <= ref_total;
          default:     reg_rdata_out <= 16'h_0000;
        endcase
      end
    end
  end

  // ************************************************************
  // sequencer
  // ************************************************************
  // each command is issued for one cycle; wait_cnt then holds nop for the
  // command's own recovery time before the next state acts
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      state          <= ST_OFF;
      wait_cnt       <= '0;
      ref_done       <= '0;
      mem_clk_en_out <= 1'b0;
      mem_cke_out    <= 1'b0;
      mem_odt_out    <= 1'b0;
      {mem_cs_n_out, mem_ras_n_out, mem_cas_n_out, mem_we_n_out} <= CMD_DESELECT;
      mem_ba_out     <= '0;
      mem_addr_out   <= '0;
    end else if (clk_en_in) begin
      {mem_cs_n_out, mem_ras_n_out, mem_cas_n_out, mem_we_n_out} <= CMD_NOP;
      // all three bank bits are driven, but bit 2 always stays low, so only banks 0 to 3 are ever addressed
      mem_ba_out   <= '0;
      mem_addr_out <= '0;
      // a running recovery count holds nop and keeps every state where it is
      if (waiting) begin
        wait_cnt <= wait_cnt - 32'h_0000_0001;
      end else begin
        case (state)
          ST_OFF: begin
            {mem_cs_n_out, mem_ras_n_out, mem_cas_n_out, mem_we_n_out} <= CMD_DESELECT;
            if (start) begin
              mem_clk_en_out <= 1'b1;
              wait_cnt       <= 32'(STABLE_WAIT);
              state          <= ST_STABLE;
            end
          end
          ST_STABLE: begin
            mem_cke_out <= 1'b1;
            wait_cnt    <= 32'(CKE_WAIT_CYCLES);
            state       <= ST_CKE_WAIT;
          end
          ST_CKE_WAIT: state <= ST_PRE1;
          ST_PRE1, ST_PRE2: begin
            {mem_cs_n_out, mem_ras_n_out, mem_cas_n_out, mem_we_n_out} <= CMD_PRECHARGE;
            mem_addr_out[BIT_ALL_BANKS] <= 1'b1;
            wait_cnt <= 32'(RP_CYCLES);
            state    <= (state == ST_PRE1) ? ST_EMR2 : ST_REF;
          end
          ST_EMR2, ST_EMR3, ST_EMR1, ST_MR_RESET, ST_MR_RUN, ST_CAL_DEF, ST_CAL_EXIT: begin
            {mem_cs_n_out, mem_ras_n_out, mem_cas_n_out, mem_we_n_out} <= CMD_MODE_SET;
            wait_cnt <= 32'(MRD_CYCLES);
            case (state)
              ST_EMR2: begin
                mem_ba_out   <= BANK_EMR2;
                mem_addr_out <= emr2_val;
                state        <= ST_EMR3;
              end
              ST_EMR3: begin
                mem_ba_out   <= BANK_EMR3;
                mem_addr_out <= emr3_val;
                state        <= ST_EMR1;
              end
              ST_EMR1: begin
                mem_ba_out   <= BANK_EMR1;
                mem_addr_out <= emr1_val;
                mem_addr_out[BIT_DLL_ENABLE] <= 1'b0;  // low enables the dll
                mem_addr_out[CAL_HI:CAL_LO]  <= CAL_EXIT;
                state        <= ST_MR_RESET;
              end
              ST_MR_RESET: begin
                mem_ba_out   <= BANK_MR;
                mem_addr_out <= mr_val;
                mem_addr_out[BIT_DLL_RESET] <= 1'b1;
                state        <= ST_PRE2;
              end
              ST_MR_RUN: begin
                mem_ba_out   <= BANK_MR;
                mem_addr_out <= mr_val;
                mem_addr_out[BIT_DLL_RESET] <= 1'b0;
                state        <= ST_LOCK;
              end
              ST_CAL_DEF: begin
                mem_ba_out   <= BANK_EMR1;
                mem_addr_out <= emr1_val;
                mem_addr_out[BIT_DLL_ENABLE] <= 1'b0;
                mem_addr_out[CAL_HI:CAL_LO]  <= CAL_DEFAULT;
                state        <= ST_CAL_EXIT;
              end
              default: begin
                mem_ba_out   <= BANK_EMR1;
                mem_addr_out <= emr1_val;
                mem_addr_out[BIT_DLL_ENABLE] <= 1'b0;
                mem_addr_out[CAL_HI:CAL_LO]  <= CAL_EXIT;
                state        <= ST_READY;
              end
            endcase
          end
          // initial refreshes are counted against min_refs; the periodic
          // refresh only goes back to ST_READY
          ST_REF, ST_AUTO_REF: begin
            {mem_cs_n_out, mem_ras_n_out, mem_cas_n_out, mem_we_n_out} <= CMD_REFRESH;
            wait_cnt <= 32'(RFC_CYCLES);
            if (state == ST_AUTO_REF) begin
              state <= ST_READY;
            end else begin
              ref_done <= ref_done + 4'h_1;
              if (ref_done + 4'h_1 >= min_refs)
                state <= ST_MR_RUN;
            end
          end
          ST_LOCK: begin
            if (lock_cnt >= 32'(DLL_LOCK_CYCLES))
              state <= ST_CAL_DEF;
          end
          ST_READY: begin
            if (ref_timer >= 32'(REFRESH_WAIT))
              state <= ST_AUTO_REF;
          end
          default: state <= ST_OFF;
        endcase
      end
    end
  end

  // ************************************************************
  // dll lock and refresh timers
  // ************************************************************
  // counting from the dll-reset command itself keeps the 200-cycle
  // spacing honest even though later steps overlap it
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      lock_cnt <= '0;
    end else if (clk_en_in) begin
      if (state == ST_MR_RESET && !waiting)
        lock_cnt <= 32'h_0000_0001;
      else if (lock_cnt != 32'h_0000_0000 && lock_cnt < 32'(DLL_LOCK_CYCLES))
        lock_cnt <= lock_cnt + 32'h_0000_0001;
    end
  end

  // the refresh timer also runs while a refresh recovers, so the spacing is
  // measured from one refresh command to the next, not from the end of recovery
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      ref_timer <= '0;
      ref_total <= '0;
    end else if (clk_en_in) begin
      if (state == ST_AUTO_REF && !waiting) begin
        ref_timer <= '0;
        ref_total <= ref_total + 16'h_0001;
      end else if (state == ST_READY && ref_timer < 32'(REFRESH_WAIT)) begin
        ref_timer <= ref_timer + 32'h_0000_0001;
      end
    end
  end

  assign ready_out = (state == ST_READY || state == ST_AUTO_REF);

endmodule

// ==== core/dpi_pkg.sv ====
package dpi_pkg;
  // ************************************************************
  // command encodings {cs_n, ras_n, cas_n, we_n}
  // ************************************************************
  localparam logic [3:0] CMD_DESELECT  = 4'h_f;
  localparam logic [3:0] CMD_NOP       = 4'h_7;
  localparam logic [3:0] CMD_PRECHARGE = 4'h_2;
  localparam logic [3:0] CMD_REFRESH   = 4'h_1;
  localparam logic [3:0] CMD_MODE_SET  = 4'h_0;

  // ************************************************************
  // bank address for each mode register
  // ************************************************************
  localparam logic [2:0] BANK_MR   = 3'h_0;
  localparam logic [2:0] BANK_EMR1 = 3'h_1;
  localparam logic [2:0] BANK_EMR2 = 3'h_2;
  localparam logic [2:0] BANK_EMR3 = 3'h_3;

  // ************************************************************
  // address field positions
  // ************************************************************
  localparam int ADDR_W          = 14;
  localparam int BIT_DLL_ENABLE  = 0;
  localparam int BIT_DLL_RESET   = 8;
  localparam int BIT_ALL_BANKS   = 10;
  localparam int CAL_LO          = 7;
  localparam int CAL_HI          = 9;
  localparam logic [2:0] CAL_DEFAULT = 3'h_7;
  localparam logic [2:0] CAL_EXIT    = 3'h_0;

  // ************************************************************
  // register offsets of the command port
  // ************************************************************
  localparam logic [3:0] REG_CONTROL = 4'h_0;
  localparam logic [3:0] REG_STATUS  = 4'h_1;
  localparam logic [3:0] REG_MR      = 4'h_2;
  localparam logic [3:0] REG_EMR1    = 4'h_3;
  localparam logic [3:0] REG_EMR2    = 4'h_4;
  localparam logic [3:0] REG_EMR3    = 4'h_5;
  localparam logic [3:0] REG_REFCNT  = 4'h_6;

  // ************************************************************
  // timing
  // ************************************************************
  localparam int CLK_PERIOD_PS    = 8000;
  localparam int STABLE_US        = 200;
  localparam int CKE_WAIT_NS      = 400;
  localparam int DLL_LOCK_CYCLES  = 200;
  localparam int REFRESH_INT_NS   = 7800;
  localparam int MIN_REFRESHES    = 2;
  localparam int STABLE_CYCLES    = (STABLE_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int CKE_WAIT_CYCLES  = (CKE_WAIT_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int REFRESH_CYCLES   = (REFRESH_INT_NS * 1000) / CLK_PERIOD_PS;
  localparam int MRD_CYCLES       = 2;
  localparam int RP_CYCLES        = 4;
  localparam int RFC_CYCLES       = 16;
endpackage

// ==== verification/dpi_init_checker.sv ====
module dpi_init_checker
  import dpi_pkg::*;
#(
  parameter int STABLE_WAIT  = 20,
  parameter int REFRESH_WAIT = 50
) (
  // clock and reset
  input wire logic              clk_in,
  input wire logic              reset_n_in,
  input wire logic              clk_en_in,
  // memory pins and status
  input wire logic              mem_clk_en_out,
  input wire logic              mem_cke_out,
  input wire logic              mem_odt_out,
  input wire logic              mem_cs_n_out,
  input wire logic              mem_ras_n_out,
  input wire logic              mem_cas_n_out,
  input wire logic              mem_we_n_out,
  input wire logic [2:0]        mem_ba_out,
  input wire logic [ADDR_W-1:0] mem_addr_out,
  input wire logic              ready_out
);
  logic [3:0] cmd;
  logic       idle, mrs, dll_rst, cal_on, cal_off;
  int         clk_cnt = 0, cke_cnt = 0, dll_cnt = 0, refs = 0, gap = 0;
  assign cmd = {mem_cs_n_out, mem_ras_n_out, mem_cas_n_out, mem_we_n_out};
  assign idle = cmd == CMD_NOP || cmd == CMD_DESELECT;
  assign mrs = cmd == CMD_MODE_SET;
  assign dll_rst = mrs && mem_ba_out == BANK_MR && mem_addr_out[BIT_DLL_RESET];
  assign cal_on = mrs && mem_ba_out == BANK_EMR1 && mem_addr_out[CAL_HI:CAL_LO] == CAL_DEFAULT;
  assign cal_off = mrs && mem_ba_out == BANK_EMR1 && mem_addr_out[CAL_HI:CAL_LO] == CAL_EXIT;
  // counters follow the design's frozen cycles so a paused clock never looks like a late refresh
  always_ff @(posedge clk_in) begin
    if (clk_en_in) begin
      clk_cnt <= mem_clk_en_out ? clk_cnt + 1 : 0;
      cke_cnt <= mem_cke_out ? cke_cnt + 1 : 0;
      dll_cnt <= dll_rst ? 1 : dll_cnt + 1;
      refs    <= dll_rst ? 0 : refs + int'(cmd == CMD_REFRESH);
      gap     <= (cmd == CMD_REFRESH || !ready_out) ? 0 : gap + 1;
    end
  end
  default clocking @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);
  odt_low_a: assert property (!mem_odt_out)
    else $error("odt driven high");
  cke_clock_a: assert property (mem_cke_out |-> mem_clk_en_out)
    else $error("cke high without memory clock");
  cke_rise_a: assert property ($rose(mem_cke_out) |-> idle && clk_cnt >= STABLE_WAIT)
    else $error("cke raised too early or with a command");
  quiet_wait_a: assert property (!idle |-> mem_cke_out && cke_cnt >= CKE_WAIT_CYCLES)
    else $error("command inside the cke wait");
  pre_all_a: assert property (cmd == CMD_PRECHARGE |-> mem_addr_out[BIT_ALL_BANKS])
    else $error("precharge not to all banks");
  mode_bank_a: assert property (mrs |-> !mem_ba_out[2] && !(mem_ba_out == BANK_EMR1 && mem_addr_out[0]))
    else $error("mode set bank or dll bit wrong");
  dll_wait_a: assert property (cal_on |-> dll_cnt >= DLL_LOCK_CYCLES)
    else $error("calibration before dll lock time");
  cal_pair_a: assert property (cal_on |-> ##[1:8] cal_off)
    else $error("calibration exit missing");
  refs_first_a: assert property (mrs && mem_ba_out == BANK_MR && !mem_addr_out[BIT_DLL_RESET] |-> refs >= MIN_REFRESHES)
    else $error("too few refreshes before mode set");
  refresh_gap_a: assert property (gap <= REFRESH_WAIT + 6)
    else $error("periodic refresh late");
endmodule

// ==== verification/dpi_mem_model.sv ====
module dpi_mem_model
  import dpi_pkg::*;
(
  // command pins
  input  wire logic              clk_in,
  input  wire logic              cke_in,
  input  wire logic              cs_n_in,
  input  wire logic              ras_n_in,
  input  wire logic              cas_n_in,
  input  wire logic              we_n_in,
  input  wire logic [2:0]        ba_in,
  input  wire logic [ADDR_W-1:0] addr_in,
  // observed state
  output logic                   ready_out,
  output logic                   bad_out,
  output logic      [3:0]        refs_out,
  output logic      [ADDR_W-1:0] regs_out [4]
);
  logic [3:0] cmd, step;
  logic       ok, mrs, bad = 1'b0;
  int         wait_cnt;
  assign cmd = {cs_n_in, ras_n_in, cas_n_in, we_n_in};
  assign mrs = cmd == CMD_MODE_SET && !ba_in[2];
  assign ready_out = step == 4'd9;
  assign bad_out = bad;
  always_comb begin
    case (step)
      4'd0: ok = cmd == CMD_PRECHARGE && addr_in[BIT_ALL_BANKS] && wait_cnt >= CKE_WAIT_CYCLES;
      4'd1: ok = mrs && ba_in == BANK_EMR2;
      4'd2: ok = mrs && ba_in == BANK_EMR3;
      4'd3: ok = mrs && ba_in == BANK_EMR1 && !addr_in[BIT_DLL_ENABLE];
      4'd4: ok = mrs && ba_in == BANK_MR && addr_in[BIT_DLL_RESET];
      4'd5: ok = cmd == CMD_PRECHARGE && addr_in[BIT_ALL_BANKS];
      4'd6: ok = cmd == CMD_REFRESH || (mrs && ba_in == BANK_MR && !addr_in[8] && refs_out >= 2);
      4'd7: ok = mrs && ba_in == BANK_EMR1 && addr_in[9:7] == CAL_DEFAULT && wait_cnt >= DLL_LOCK_CYCLES;
      4'd8: ok = mrs && ba_in == BANK_EMR1 && addr_in[CAL_HI:CAL_LO] == CAL_EXIT;
      default: ok = cmd == CMD_REFRESH;
    endcase
  end
  always @(posedge clk_in) begin
    // no reset pin: a low clock enable is the only way back to the start
    if (!cke_in) begin
      step <= 4'd0;
      refs_out <= 4'd0;
      wait_cnt <= 0;
    end else begin
      wait_cnt <= wait_cnt + 1;
      if (cmd != CMD_NOP && cmd != CMD_DESELECT) begin
        if (!ok) bad <= 1'b1;
        if (mrs) regs_out[ba_in[1:0]] <= addr_in;
        if (step == 4'd6 && cmd == CMD_REFRESH) refs_out <= refs_out + 4'd1;
        if (step == 4'd4) wait_cnt <= 1;
        if (step != 4'd9 && !(step == 4'd6 && cmd == CMD_REFRESH)) step <= step + 4'd1;
      end
    end
  end
endmodule

// ==== verification/tb_dpi_init_ctrl.sv ====
module tb_dpi_init_ctrl import dpi_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int RW = 50;
  logic              clk_in, reset_n_in, clk_en_in, reg_write_in, reg_read_in, rd_d;
  logic              mem_clk_en_out, mem_cke_out, mem_odt_out, ready_out, m_ready, m_bad;
  logic              mem_cs_n_out, mem_ras_n_out, mem_cas_n_out, mem_we_n_out;
  logic [3:0]        reg_addr_in, m_refs;
  logic [2:0]        mem_ba_out;
  logic [15:0]       reg_wdata_in, reg_rdata_out;
  logic [ADDR_W-1:0] mem_addr_out, val [4], m_regs [4];
  logic [31:0]       seed, notes [$];
  int                err_count, comparisons;
  dpi_init_ctrl #(.STABLE_WAIT(20), .REFRESH_WAIT(RW)) u_dpi_init_ctrl (.*);
  dpi_mem_model u_dpi_mem_model (.clk_in, .cke_in(mem_cke_out), .cs_n_in(mem_cs_n_out), .ras_n_in(mem_ras_n_out),
    .cas_n_in(mem_cas_n_out), .we_n_in(mem_we_n_out), .ba_in(mem_ba_out), .addr_in(mem_addr_out),
    .ready_out(m_ready), .bad_out(m_bad), .refs_out(m_refs), .regs_out(m_regs));
  // ****
  // bus tasks and compares
  // ****
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  task automatic check_val(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic check_rd();
    logic [31:0] n;
    n = notes.pop_front();
    check_val(reg_rdata_out & n[31:16], n[15:0]);
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_write_in <= 1'b1;
    @(posedge clk_in);
    reg_write_in <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] exp, input logic [15:0] msk);
    @(posedge clk_in);
    notes.push_back({msk, exp & msk});
    reg_addr_in <= a;
    reg_read_in <= 1'b1;
    @(posedge clk_in);
    reg_read_in <= 1'b0;
  endtask
  task automatic wrap_up();
    $display("comparisons=%0d err_count=%0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic wait_ready();
    for (int i = 0; i < 3000 && ready_out !== 1'b1; i++) @(posedge clk_in);
    if (ready_out !== 1'b1) begin
      check_val(16'(ready_out), 16'h_0001);
      wrap_up();
    end
    // the last calibration command reaches the model one edge after ready rises
    repeat (2) @(posedge clk_in);
  endtask
  task automatic pulse_reset(input string name);
    @(posedge clk_in);
    reset_n_in <= 1'b0;
    repeat (6) @(posedge clk_in);
    reset_n_in <= 1'b1;
    @(negedge clk_in);
    check_val({mem_cke_out, mem_clk_en_out, ready_out}, 16'h_0000);
    $display("test %s done", name);
  endtask
  initial begin
    clk_in = 1'b0;
    forever #4 clk_in = ~clk_in;
  end
  always @(posedge clk_in) rd_d <= reg_read_in;
  always @(negedge clk_in) if (rd_d === 1'b1) check_rd();
  // ****
  // scenarios
  // ****
  initial begin
    {reset_n_in, reg_write_in, reg_read_in, reg_addr_in, reg_wdata_in} = '0;
    clk_en_in = 1'b1;
    seed = 32'h165d_26fa;
    pulse_reset("reset");
    for (int a = 1; a < 6; a++) rd(4'(a), 16'h_0000, a == 1 ? 16'h_003f : 16'h_ffff);
    rd(4'h_f, 16'h_0000, 16'h_ffff);
    // counts below two are refused, so the default of two refreshes stays
    wr(REG_CONTROL, 16'h_0010);
    wr(REG_CONTROL, 16'h_0001);
    wait_ready();
    check_val({m_ready, m_bad, m_refs}, 16'h_0022);
    repeat (4 * (RW + 8)) @(posedge clk_in);
    wr(REG_CONTROL, 16'h_0001);
    repeat (20) @(posedge clk_in);
    check_val({ready_out, m_bad}, 16'h_0002);
    pulse_reset("default_init");
    for (int i = 0; i < 4; i++) begin
      seed = xs(seed);
      val[i] = seed[13:0];
      wr(REG_MR + 4'(i), seed[15:0]);
      rd(REG_MR + 4'(i), {2'b00, seed[13:0]}, 16'h_ffff);
    end
    wr(REG_CONTROL, 16'h_0030);
    wr(REG_CONTROL, 16'h_0031);
    wait_ready();
    rd(REG_STATUS, 16'h_0020, 16'h_0020);
    check_val({m_bad, m_refs}, 16'h_0003);
    check_val(16'(m_regs[0]), 16'(val[0] & 14'h_3eff));
    check_val(16'(m_regs[1]), 16'(val[1] & 14'h_3c7e));
    check_val(16'(m_regs[2]), 16'(val[2]));
    check_val(16'(m_regs[3]), 16'(val[3]));
    pulse_reset("programmed_init");
    wr(REG_CONTROL, 16'h_0001);
    repeat (90) @(posedge clk_in);
    pulse_reset("abort");
    check_val(16'(m_bad), 16'h_0000);
    repeat (2) @(posedge clk_in);
    wrap_up();
  end
endmodule
bind dpi_init_ctrl dpi_init_checker #(.STABLE_WAIT(STABLE_WAIT), .REFRESH_WAIT(REFRESH_WAIT)) u_dpi_init_checker (.*);
